// ### src/stpio_pkg.sv
package stpio_pkg;

  // clock rate and derived blink timing
  localparam int unsigned CLK_HZ          = 20_000_000;
  localparam int unsigned FAST_BLINK_HZ   = 4;
  localparam int unsigned SLOW_BLINK_HZ   = 1;
  localparam int unsigned ERR_ON_MS       = 200;
  localparam int unsigned ERR_OFF_MS      = 1000;
  localparam int unsigned NVM_BLINK_HZ    = 2;
  localparam int unsigned TRAFFIC_BLINK_HZ = 10;
  localparam int unsigned FAST_HALF_CYC   = CLK_HZ / (2 * FAST_BLINK_HZ);
  localparam int unsigned SLOW_HALF_CYC   = CLK_HZ / (2 * SLOW_BLINK_HZ);
  localparam int unsigned ERR_ON_CYC      = CLK_HZ / 1000 * ERR_ON_MS;
  localparam int unsigned ERR_OFF_CYC     = CLK_HZ / 1000 * ERR_OFF_MS;
  localparam int unsigned NVM_HALF_CYC    = CLK_HZ / (2 * NVM_BLINK_HZ);
  localparam int unsigned TRAF_HALF_CYC   = CLK_HZ / (2 * TRAFFIC_BLINK_HZ);

  // register byte addresses
  localparam logic [7:0] ADDR_IN_CFG   = 8'h00;
  localparam logic [7:0] ADDR_DRV_CFG  = 8'h04;
  localparam logic [7:0] ADDR_MOVE_CMD = 8'h08;
  localparam logic [7:0] ADDR_STATUS   = 8'h0C;
  localparam logic [7:0] ADDR_ENC_CAP  = 8'h10;
  localparam logic [7:0] ADDR_LINK     = 8'h14;

  // field positions
  localparam int unsigned DRV_IDLE_LSB = 0;
  localparam int unsigned DRV_GAIN_LSB = 8;
  localparam int unsigned DRV_ENC_BIT  = 16;
  localparam int unsigned IN_SENSE_LSB = 12;

  // reset values and ranges
  localparam logic [6:0] IDLE_PCT_RST = 7'h64;
  localparam logic [6:0] IDLE_PCT_MAX = 7'h64;
  localparam logic [5:0] GAIN_RST     = 6'h01;
  localparam logic [5:0] GAIN_MIN     = 6'h01;
  localparam logic [5:0] GAIN_MAX     = 6'h28;

  // input function codes
  typedef enum logic [3:0] {
    STPIO_FN_GP, STPIO_FN_HOME, STPIO_FN_CWLIM, STPIO_FN_CCWLIM,
    STPIO_FN_START, STPIO_FN_ESTOP, STPIO_FN_STOPJOG
  } stpio_fn_t;

  // move kinds
  typedef enum logic [2:0] {
    STPIO_MV_REL, STPIO_MV_JOG, STPIO_MV_REG, STPIO_MV_HOME, STPIO_MV_INDEX
  } stpio_mv_t;

  // network link state
  typedef enum logic [1:0] {
    STPIO_NS_INIT, STPIO_NS_PREOP, STPIO_NS_SAFEOP, STPIO_NS_OP
  } stpio_ns_t;

  // motion request toward the profile engine
  typedef struct packed {
    logic      start;
    logic      dir_ccw;
    stpio_mv_t kind;
  } stpio_move_t;

  // driver health flags
  typedef struct packed {
    logic short_flt;
    logic temp_flt;
    logic ilock_open;
  } stpio_flt_t;

endpackage

// ### src/stpio_top.sv
// Decided for this implementation: the AHB-Lite slave port and the address map.
`timescale 1ns/1ns
`default_nettype none
module stpio_top
  import stpio_pkg::*;
(
  // clock and reset
  input  wire logic               clk,
  input  wire logic               rst,
  // ahb-lite slave
  input  wire logic               hsel,
  input  wire logic [7:0]         haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic [31:0]        hwdata,
  input  wire logic               hready,
  output logic [31:0]             hrdata,
  output logic                    hreadyout,
  output logic                    hresp,
  // field pins
  input  wire logic [2:0]         in_pin,
  // motion engine side
  input  wire logic               motion_busy,
  input  wire stpio_pkg::stpio_mv_t motion_kind,
  input  wire logic               motion_ccw,
  input  wire logic               current_en,
  input  wire stpio_pkg::stpio_flt_t flt_raw,
  input  wire logic               nvm_done,
  input  wire logic               nvm_ok,
  input  wire logic [31:0]        enc_pos,
  output stpio_pkg::stpio_move_t  move_req,
  output logic                    halt_now,
  output logic                    decel_stop,
  output logic                    home_found,
  output logic                    peak_mode,
  output logic [6:0]              idle_pct,
  output logic [5:0]              loop_gain,
  output logic [1:0]              quad_ab,
  // network side
  input  wire logic [1:0]         link_up,
  input  wire logic [1:0]         link_act,
  input  wire stpio_pkg::stpio_ns_t net_state,
  input  wire logic               sync_err,
  // indicators
  output logic                    led_green,
  output logic                    led_red,
  output logic [1:0]              led_link,
  output logic                    led_run,
  output logic                    led_err
);
  import stpio_pkg::*;

  logic [11:0] in_fn_q;
  logic [2:0]  in_sense_q;
  logic [6:0]  idle_q;
  logic [5:0]  gain_q;
  logic        enc_en_q;
  logic        pend_q;
  stpio_mv_t   pend_kind_q;
  logic        pend_ccw_q;
  logic [31:0] cap_q;
  logic        cw_block_q, ccw_block_q;
  logic [2:0]  s1_q, s2_q, act_q, act_prev_q;
  logic [2:0]  rise, fall;
  logic        ph_q, ph_wr_q;
  logic [7:0]  ph_addr_q;
  logic [2:0]  nvm_q;
  logic [24:0] slow_q, fast_q, nvm_cnt_q, traf_q, err_cnt_q;
  logic        slow_t_q, fast_t_q, nvm_t_q, traf_t_q, err_on_q;

  // function of input n
  function automatic logic [3:0] fn_of(input logic [11:0] f,
                                       input int n);
    fn_of = f[n*4 +: 4];
  endfunction

  // any input with function fn active now
  function automatic logic fn_level(input logic [11:0] f,
                                    input logic [2:0] lv,
                                    input logic [3:0] fn);
    fn_level = 1'b0;
    for (int i = 0; i < 3; i++) begin
      if (fn_of(f, i) == fn && lv[i]) begin
        fn_level = 1'b1;
      end
    end
  endfunction

  // synchronise pins, then apply sense (nc inverts)
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_q <= 3'h0;
      s2_q <= 3'h0;
      act_q <= 3'h0;
      act_prev_q <= 3'h0;
    end else begin
      s1_q <= in_pin;
      s2_q <= s1_q;
      act_q <= s2_q ^ in_sense_q;
      act_prev_q <= act_q;
    end
  end

  assign rise = act_q & ~act_prev_q;
  assign fall = ~act_q & act_prev_q;

  // encoder mode hides inputs 1 and 2 from the function map
  logic [2:0] fn_mask;
  assign fn_mask = enc_en_q ? 3'h4 : 3'h7;

  logic estop_lv, cw_lv, ccw_lv, home_ev, start_ev, stopjog_ev, jog_run;
  assign estop_lv = fn_level(in_fn_q, act_q & fn_mask, STPIO_FN_ESTOP);
  assign cw_lv    = fn_level(in_fn_q, act_q & fn_mask, STPIO_FN_CWLIM);
  assign ccw_lv   = fn_level(in_fn_q, act_q & fn_mask, STPIO_FN_CCWLIM);
  assign home_ev  = fn_level(in_fn_q, rise & fn_mask, STPIO_FN_HOME);
  assign start_ev = fn_level(in_fn_q, rise & fn_mask, STPIO_FN_START);
  assign stopjog_ev = fn_level(in_fn_q, rise & fn_mask, STPIO_FN_STOPJOG);
  assign jog_run  = motion_busy &&
                    (motion_kind == STPIO_MV_JOG ||
                     motion_kind == STPIO_MV_REG);

  logic cw_hit, ccw_hit;
  assign cw_hit  = cw_lv && motion_busy && !motion_ccw;
  assign ccw_hit = ccw_lv && motion_busy && motion_ccw;

  // ahb address phase capture
  logic ph_take;
  assign ph_take = hsel && hready && htrans[1];
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ph_q <= 1'b0;
      ph_wr_q <= 1'b0;
      ph_addr_q <= 8'h00;
    end else begin
      ph_q <= ph_take;
      ph_wr_q <= ph_take && hwrite;
      ph_addr_q <= haddr;
    end
  end

  logic wr_cmd;
  assign wr_cmd = ph_wr_q && ph_addr_q == ADDR_MOVE_CMD;

  // configuration registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      in_fn_q <= 12'h000;
      in_sense_q <= 3'h0;
      idle_q <= IDLE_PCT_RST;
      gain_q <= GAIN_RST;
      enc_en_q <= 1'b0;
    end else if (ph_wr_q && ph_addr_q == ADDR_IN_CFG) begin
      in_fn_q <= hwdata[11:0];
      in_sense_q <= hwdata[IN_SENSE_LSB +: 3];
    end else if (ph_wr_q && ph_addr_q == ADDR_DRV_CFG) begin
      // out of range values are clamped, not refused
      idle_q <= (hwdata[DRV_IDLE_LSB +: 7] > IDLE_PCT_MAX) ?
                IDLE_PCT_MAX : hwdata[DRV_IDLE_LSB +: 7];
      gain_q <= (hwdata[DRV_GAIN_LSB +: 6] > GAIN_MAX) ? GAIN_MAX :
                (hwdata[DRV_GAIN_LSB +: 6] < GAIN_MIN) ? GAIN_MIN :
                hwdata[DRV_GAIN_LSB +: 6];
      enc_en_q <= hwdata[DRV_ENC_BIT];
    end
  end

  // pending indexer move and launch
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pend_q <= 1'b0;
      pend_kind_q <= STPIO_MV_INDEX;
      pend_ccw_q <= 1'b0;
      move_req <= '0;
    end else begin
      move_req.start <= 1'b0;
      if (pend_q && start_ev && !estop_lv &&
          !(pend_ccw_q ? ccw_block_q : cw_block_q)) begin
        pend_q <= 1'b0;
        move_req <= '{start: 1'b1, dir_ccw: pend_ccw_q, kind: pend_kind_q};
      end else if (wr_cmd && hwdata[3:1] == STPIO_MV_INDEX) begin
        pend_q <= 1'b1;
        pend_ccw_q <= hwdata[4];
        pend_kind_q <= STPIO_MV_INDEX;
      end else if (wr_cmd && hwdata[0] && !estop_lv &&
                   !(hwdata[4] ? ccw_block_q : cw_block_q)) begin
        move_req <= '{start: 1'b1, dir_ccw: hwdata[4],
                      kind: stpio_mv_t'(hwdata[3:1])};
      end
    end
  end

  // limit direction blocking, released by a move the other way started while that limit input is inactive
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cw_block_q <= 1'b0;
      ccw_block_q <= 1'b0;
    end else begin
      if (cw_hit) begin
        cw_block_q <= 1'b1;
      end else if (move_req.start && move_req.dir_ccw && !cw_lv) begin
        cw_block_q <= 1'b0;
      end
      if (ccw_hit) begin
        ccw_block_q <= 1'b1;
      end else if (move_req.start && !move_req.dir_ccw && !ccw_lv) begin
        ccw_block_q <= 1'b0;
      end
    end
  end

  // stop strobes toward the profile engine
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      halt_now <= 1'b0;
      decel_stop <= 1'b0;
      home_found <= 1'b0;
    end else begin
      halt_now <= estop_lv || cw_hit || ccw_hit;
      decel_stop <= stopjog_ev && jog_run;
      home_found <= home_ev && motion_busy &&
                    motion_kind == STPIO_MV_HOME;
    end
  end

  // encoder capture on input 3
  logic cap_ev;
  assign cap_ev = enc_en_q &&
    ((fn_of(in_fn_q, 2) == STPIO_FN_START && (rise[2] || fall[2])) ||
     (fn_of(in_fn_q, 2) == STPIO_FN_STOPJOG && rise[2] && jog_run));
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cap_q <= 32'h0000_0000;
    end else if (cap_ev) begin
      cap_q <= enc_pos;
    end
  end

  // drive outputs: peak control while idle, encoder lines forwarded
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      peak_mode <= 1'b1;
      idle_pct <= IDLE_PCT_RST;
      loop_gain <= GAIN_RST;
      quad_ab <= 2'h0;
    end else begin
      peak_mode <= !motion_busy;
      idle_pct <= idle_q;
      loop_gain <= gain_q;
      quad_ab <= enc_en_q ? s2_q[1:0] : 2'h0;
    end
  end

  // ahb read data; general purpose levels visible in status
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hrdata <= 32'h0000_0000;
    end else if (ph_take && !hwrite) begin
      case (haddr)
        ADDR_IN_CFG:   hrdata <= {17'h0_0000, in_sense_q, in_fn_q};
        ADDR_DRV_CFG:  hrdata <= {15'h0000, enc_en_q, 2'h0, gain_q,
                                  1'b0, idle_q};
        ADDR_MOVE_CMD: hrdata <= {31'h0000_0000, pend_q};
        ADDR_STATUS:   hrdata <= {24'h00_0000, ccw_block_q, cw_block_q,
                                  estop_lv, 2'h0, act_q};
        ADDR_ENC_CAP:  hrdata <= cap_q;
        default:       hrdata <= 32'h0000_0000;
      endcase
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // nvm write result latches until power cycle (reset)
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      nvm_q <= 3'h0;
    end else if (nvm_done && !nvm_q[2]) begin
      nvm_q <= {1'b1, nvm_ok, !nvm_ok};
    end
  end

  // free running blink dividers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      slow_q <= 25'h000_0000;
      fast_q <= 25'h000_0000;
      nvm_cnt_q <= 25'h000_0000;
      traf_q <= 25'h000_0000;
      slow_t_q <= 1'b0;
      fast_t_q <= 1'b0;
      nvm_t_q <= 1'b0;
      traf_t_q <= 1'b0;
    end else begin
      slow_q <= (slow_q == 25'(SLOW_HALF_CYC - 1)) ? '0 : slow_q + 1'b1;
      fast_q <= (fast_q == 25'(FAST_HALF_CYC - 1)) ? '0 : fast_q + 1'b1;
      nvm_cnt_q <= (nvm_cnt_q == 25'(NVM_HALF_CYC - 1)) ? '0 :
                   nvm_cnt_q + 1'b1;
      traf_q <= (traf_q == 25'(TRAF_HALF_CYC - 1)) ? '0 : traf_q + 1'b1;
      if (slow_q == 25'(SLOW_HALF_CYC - 1)) slow_t_q <= !slow_t_q;
      if (fast_q == 25'(FAST_HALF_CYC - 1)) fast_t_q <= !fast_t_q;
      if (nvm_cnt_q == 25'(NVM_HALF_CYC - 1)) nvm_t_q <= !nvm_t_q;
      if (traf_q == 25'(TRAF_HALF_CYC - 1)) traf_t_q <= !traf_t_q;
    end
  end

  // error led single blink, restarted cleanly when sync error clears
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      err_cnt_q <= 25'h000_0000;
      err_on_q <= 1'b0;
    end else if (!sync_err) begin
      err_cnt_q <= '0;
      err_on_q <= 1'b0;
    end else if (err_on_q && err_cnt_q == 25'(ERR_ON_CYC - 1)) begin
      err_cnt_q <= '0;
      err_on_q <= 1'b0;
    end else if (!err_on_q && err_cnt_q == 25'(ERR_OFF_CYC - 1)) begin
      err_cnt_q <= '0;
      err_on_q <= 1'b1;
    end else begin
      err_cnt_q <= err_cnt_q + 1'b1;
    end
  end

  // faults only count while current is enabled
  logic fault;
  assign fault = current_en && (|flt_raw);

  // indicators
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      led_green <= 1'b0;
      led_red <= 1'b0;
      led_link <= 2'h0;
      led_run <= 1'b0;
      led_err <= 1'b0;
    end else begin
      if (nvm_q[2]) begin
        led_green <= nvm_q[1] && nvm_t_q;
        led_red <= nvm_q[0] && nvm_t_q;
      end else begin
        led_green <= !fault;
        led_red <= fault;
      end
      for (int p = 0; p < 2; p++) begin
        led_link[p] <= link_up[p] && !(link_act[p] && traf_t_q);
      end
      case (net_state)
        STPIO_NS_INIT:   led_run <= 1'b0;
        STPIO_NS_PREOP:  led_run <= fast_t_q;
        STPIO_NS_SAFEOP: led_run <= slow_t_q;
        STPIO_NS_OP:     led_run <= 1'b1;
        default:         led_run <= 1'b0;
      endcase
      led_err <= err_on_q;
    end
  end

  // estop halts at once and blocks starts
  AST_ESTOP_HALT: assert property (@(posedge clk) disable iff (rst)
    estop_lv |=> halt_now && !move_req.start)
    else $error("estop did not halt");
  AST_ESTOP_NOSTART: assert property (@(posedge clk) disable iff (rst)
    $past(estop_lv) |-> !move_req.start)
    else $error("move began during estop");
  AST_CW_BLOCK: assert property (@(posedge clk) disable iff (rst)
    cw_hit |=> cw_block_q)
    else $error("cw limit not latched");
  AST_CCW_BLOCK: assert property (@(posedge clk) disable iff (rst)
    ccw_hit |=> ccw_block_q)
    else $error("ccw limit not latched");
  AST_NO_CW_START: assert property (@(posedge clk) disable iff (rst)
    move_req.start && !move_req.dir_ccw |-> !$past(cw_block_q))
    else $error("cw move while blocked");
  AST_DECEL_JOG: assert property (@(posedge clk) disable iff (rst)
    decel_stop |-> $past(jog_run) && $past(stopjog_ev))
    else $error("stop on wrong move");
  AST_GAIN_RANGE: assert property (@(posedge clk) disable iff (rst)
    gain_q >= GAIN_MIN && gain_q <= GAIN_MAX)
    else $error("gain out of range");
  AST_IDLE_RANGE: assert property (@(posedge clk) disable iff (rst)
    idle_q <= IDLE_PCT_MAX)
    else $error("idle pct out of range");
  AST_PEAK_IDLE: assert property (@(posedge clk) disable iff (rst)
    !motion_busy ##1 !$past(motion_busy) |-> peak_mode)
    else $error("not peak when idle");
  AST_FAULT_RED: assert property (@(posedge clk) disable iff (rst)
    !nvm_q[2] && current_en && |flt_raw ##1 !nvm_q[2] |-> led_red)
    else $error("fault not red");
  AST_NOFLT_OFF: assert property (@(posedge clk) disable iff (rst)
    !current_en && !nvm_q[2] ##1 !nvm_q[2] |-> led_green)
    else $error("fault shown with current off");
  AST_CAP: assert property (@(posedge clk) disable iff (rst)
    cap_ev |=> cap_q == $past(enc_pos))
    else $error("encoder not captured");

endmodule
`default_nettype wire

// ### verif/stpio_motion_model.sv
`timescale 1ns/1ns
`default_nettype none
module stpio_motion_model
  import stpio_pkg::*;
#(
  parameter int RUN_CYC = 100
)(
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   rst,
  // requests from the block
  input  wire stpio_pkg::stpio_move_t move_req,
  input  wire logic                   halt_now,
  input  wire logic                   decel_stop,
  // move status back to the block
  output logic                        motion_busy,
  output stpio_pkg::stpio_mv_t        motion_kind,
  output logic                        motion_ccw
);
  import stpio_pkg::*;
  logic [7:0] left_q;
  // profile engine stand-in: fixed run time, no real ramp
  // a decel stop ends at once; the ramp itself is out of scope
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      left_q      <= 8'h00;
      motion_kind <= STPIO_MV_REL;
      motion_ccw  <= 1'b0;
    end else if (move_req.start) begin
      left_q      <= 8'(RUN_CYC);
      motion_kind <= move_req.kind;
      motion_ccw  <= move_req.dir_ccw;
    end else if (halt_now || decel_stop) begin
      left_q <= 8'h00;
    end else if (left_q != 8'h00) begin
      left_q <= left_q - 8'h01;
    end
  end
  assign motion_busy = (left_q != 8'h00);
endmodule
`default_nettype wire

// ### verif/stpio_top_bench.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, got) \
  begin \
    comparisons++; \
    if ((got) !== (ex)) begin \
      errors++; \
      $display("Error %s expected %0h seen %0h", nm, ex, got); \
    end \
  end
module stpio_top_bench;
  import stpio_pkg::*;
  logic clk, rst, hsel, hwrite, hresp, hreadyout, current_en;
  logic nvm_done, nvm_ok, motion_busy, motion_ccw, sync_err;
  logic halt_now, decel_stop, home_found, peak_mode;
  logic led_green, led_red, led_run, led_err;
  logic [7:0]  haddr;
  logic [1:0]  htrans, quad_ab, link_up, link_act, led_link;
  logic [2:0]  hsize, in_pin;
  logic [31:0] hwdata, hrdata, enc_pos, q;
  logic [6:0]  idle_pct;
  logic [5:0]  loop_gain;
  wire logic   hready;
  stpio_mv_t   motion_kind;
  stpio_flt_t  flt_raw;
  stpio_ns_t   net_state;
  stpio_move_t move_req;
  int errors, comparisons, starts, decels, homes, cyc;

  assign hready = hreadyout;

  stpio_top i_stpio_top (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .in_pin(in_pin), .motion_busy(motion_busy), .motion_kind(motion_kind),
    .motion_ccw(motion_ccw), .current_en(current_en), .flt_raw(flt_raw),
    .nvm_done(nvm_done), .nvm_ok(nvm_ok), .enc_pos(enc_pos),
    .move_req(move_req), .halt_now(halt_now), .decel_stop(decel_stop),
    .home_found(home_found), .peak_mode(peak_mode), .idle_pct(idle_pct),
    .loop_gain(loop_gain), .quad_ab(quad_ab), .link_up(link_up),
    .link_act(link_act), .net_state(net_state), .sync_err(sync_err),
    .led_green(led_green), .led_red(led_red), .led_link(led_link),
    .led_run(led_run), .led_err(led_err));

  stpio_motion_model i_stpio_motion_model (.clk(clk), .rst(rst),
    .move_req(move_req), .halt_now(halt_now), .decel_stop(decel_stop),
    .motion_busy(motion_busy), .motion_kind(motion_kind),
    .motion_ccw(motion_ccw));

  // 20 MHz clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // pulse counters and hang guard
  always @(posedge clk) begin
    cyc++;
    if (move_req.start === 1'b1) starts++;
    if (decel_stop === 1'b1) decels++;
    if (home_found === 1'b1) homes++;
    if (cyc == 20000) begin
      errors++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask

  // one ahb-lite single word transfer, waits on hready both phases
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] rd);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    htrans <= 2'h0;
    hsel   <= 1'b0;
    hwdata <= d;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    rd = hrdata;
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] dummy;
    bus(1'b1, a, d, dummy);
  endtask

  // pin change, then enough cycles for sync, sense and edge stages
  task automatic pins(input logic [2:0] v);
    in_pin <= v;
    wt(8);
  endtask

  task automatic done(input string nm);
    $display("test %s done", nm);
  endtask

  initial begin
    int s0;
    rst = 1'b1; hsel = 1'b0; haddr = 8'h00; htrans = 2'h0; hwrite = 1'b0;
    hsize = 3'h2; hwdata = 32'h0000_0000; in_pin = 3'b000;
    current_en = 1'b0; flt_raw = '0; nvm_done = 1'b0; nvm_ok = 1'b0;
    enc_pos = 32'h0000_0000; link_up = 2'b00; link_act = 2'b00;
    net_state = STPIO_NS_INIT; sync_err = 1'b0;
    errors = 0; comparisons = 0; starts = 0; decels = 0; homes = 0;
    cyc = 0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    // reset values and drive settings with clamping
    `CHK("idle_pct", 7'h64, idle_pct)
    `CHK("loop_gain", 6'h01, loop_gain)
    `CHK("peak_mode", 1'b1, peak_mode)
    reg_wr(ADDR_DRV_CFG, 32'h0000_2819);
    wt(2);
    `CHK("idle_pct", 7'h19, idle_pct)
    `CHK("loop_gain", 6'h28, loop_gain)
    reg_wr(ADDR_DRV_CFG, 32'h0000_3F7F);
    wt(2);
    `CHK("idle_pct", 7'h64, idle_pct)
    `CHK("loop_gain", 6'h28, loop_gain)
    reg_wr(ADDR_DRV_CFG, 32'h0000_0000);
    wt(2);
    `CHK("loop_gain", 6'h01, loop_gain)
    done("settings");
    // estop, gp with closed sense, start input
    reg_wr(ADDR_IN_CFG, 32'h0000_2405);
    pins(3'b000);
    bus(1'b0, ADDR_STATUS, 32'h0, q);
    `CHK("active", 3'b010, q[2:0])
    pins(3'b011);
    `CHK("gp no motion", 0, starts)
    `CHK("halt_now", 1'b1, halt_now)
    bus(1'b0, ADDR_STATUS, 32'h0, q);
    `CHK("estop flag", 1'b1, q[5])
    reg_wr(ADDR_MOVE_CMD, 32'h0000_0003);
    reg_wr(ADDR_MOVE_CMD, 32'h0000_0008);
    bus(1'b0, ADDR_MOVE_CMD, 32'h0, q);
    `CHK("pending", 1'b1, q[0])
    pins(3'b101);
    `CHK("estop refuse", 0, starts)
    pins(3'b000);
    `CHK("halt_now", 1'b0, halt_now)
    reg_wr(ADDR_MOVE_CMD, 32'h0000_0008);
    wt(8);
    `CHK("held", 0, starts)
    pins(3'b100);
    `CHK("launch", 1, starts)
    `CHK("kind", STPIO_MV_INDEX, motion_kind)
    done("estop_start");
    // stop-jog and cw limit
    reg_wr(ADDR_IN_CFG, 32'h0000_0602);
    pins(3'b000);
    reg_wr(ADDR_MOVE_CMD, 32'h0000_0001);
    wt(2);
    pins(3'b100);
    `CHK("decel rel", 0, decels)
    pins(3'b000);
    reg_wr(ADDR_MOVE_CMD, 32'h0000_0003);
    wt(2);
    pins(3'b100);
    `CHK("decel jog", 1, decels)
    pins(3'b000);
    reg_wr(ADDR_MOVE_CMD, 32'h0000_0001);
    wt(2);
    in_pin <= 3'b001;
    wt(5);
    `CHK("cw halt", 1'b1, halt_now)
    wt(3);
    `CHK("cw stopped", 1'b0, motion_busy)
    bus(1'b0, ADDR_STATUS, 32'h0, q);
    `CHK("cw blocked", 1'b1, q[6])
    s0 = starts;
    reg_wr(ADDR_MOVE_CMD, 32'h0000_0001);
    wt(4);
    `CHK("cw refused", s0, starts)
    reg_wr(ADDR_MOVE_CMD, 32'h0000_0011);
    wt(4);
    `CHK("ccw allowed", s0 + 1, starts)
    done("limits");
    // encoder mode, capture, index homing
    reg_wr(ADDR_DRV_CFG, 32'h0001_0164);
    reg_wr(ADDR_IN_CFG, 32'h0000_0400);
    enc_pos <= 32'h1234_5678;
    pins(3'b011);
    `CHK("quad_ab", 2'b11, quad_ab)
    pins(3'b111);
    bus(1'b0, ADDR_ENC_CAP, 32'h0, q);
    `CHK("cap rise", 32'h1234_5678, q)
    enc_pos <= 32'hABCD_0001;
    pins(3'b011);
    bus(1'b0, ADDR_ENC_CAP, 32'h0, q);
    `CHK("cap fall", 32'hABCD_0001, q)
    reg_wr(ADDR_IN_CFG, 32'h0000_0600);
    enc_pos <= 32'h0000_5555;
    pins(3'b111);
    bus(1'b0, ADDR_ENC_CAP, 32'h0, q);
    `CHK("cap idle", 32'hABCD_0001, q)
    pins(3'b000);
    reg_wr(ADDR_MOVE_CMD, 32'h0000_0013);
    wt(2);
    pins(3'b100);
    bus(1'b0, ADDR_ENC_CAP, 32'h0, q);
    `CHK("cap jog", 32'h0000_5555, q)
    `CHK("decel cap", 2, decels)
    pins(3'b000);
    reg_wr(ADDR_IN_CFG, 32'h0000_0100);
    reg_wr(ADDR_MOVE_CMD, 32'h0000_0017);
    wt(2);
    pins(3'b100);
    `CHK("home found", 1, homes)
    `CHK("peak busy", 1'b0, peak_mode)
    done("encoder");
    // indicators and unmapped space
    flt_raw <= 3'b100;
    wt(4);
    `CHK("red off", 1'b0, led_red)
    current_en <= 1'b1;
    wt(4);
    `CHK("red on", 1'b1, led_red)
    flt_raw <= 3'b000;
    net_state <= STPIO_NS_OP;
    link_up <= 2'b01;
    wt(4);
    `CHK("green", 1'b1, led_green)
    `CHK("run", 1'b1, led_run)
    `CHK("link", 2'b01, led_link)
    `CHK("err", 1'b0, led_err)
    nvm_ok <= 1'b1;
    nvm_done <= 1'b1;
    wt(1);
    nvm_done <= 1'b0;
    wt(3);
    `CHK("nvm blink", 1'b0, led_green)
    `CHK("nvm red", 1'b0, led_red)
    `CHK("hresp", 1'b0, hresp)
    bus(1'b0, ADDR_LINK, 32'h0, q);
    `CHK("unmapped", 32'h0000_0000, q)
    done("indicators");
    give_verdict();
  end
endmodule
`default_nettype wire
